// *** hw/ufsd_buf.v ***
// two-entry byte buffer with valid/ready on both sides
// assumes: one clock, asynchronous active-high reset, clock enable
`timescale 1ns/10ps
`default_nettype none
`include "ufsd_defs.vh"

module ufsd_buf (
	// clock and reset
	input wire i_clk_sys,
	input wire i_rst,
	input wire i_ce,
	input wire i_flush,
	// fill side
	input wire i_in_valid,
	input wire [`UFSD_BYTE_W-1:0] i_in_data,
	output wire o_in_ready,
	// drain side
	output wire o_out_valid,
	output wire [`UFSD_BYTE_W-1:0] o_out_data,
	input wire i_out_ready
);
	reg [`UFSD_BYTE_W-1:0] ent0_q;
	reg [`UFSD_BYTE_W-1:0] ent1_q;
	reg [`UFSD_BUF_CNT_W-1:0] cnt_q;
	wire push;
	wire pop;

	assign o_in_ready = (cnt_q != `UFSD_BUF_DEPTH);
	assign o_out_valid = (cnt_q != `UFSD_BUF_EMPTY);
	assign o_out_data = ent0_q;
	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;

	always @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			ent0_q <= 8'h00;
			ent1_q <= 8'h00;
			cnt_q <= `UFSD_BUF_EMPTY;
		end else if (i_ce) begin
			if (i_flush) begin
				cnt_q <= `UFSD_BUF_EMPTY;
			end else begin
				// head moves up on pop, new byte lands behind what stays
				if (pop) begin
					ent0_q <= (cnt_q == `UFSD_BUF_DEPTH) ? ent1_q : i_in_data;
				end else if (push && cnt_q == `UFSD_BUF_EMPTY) begin
					ent0_q <= i_in_data;
				end
				if (push && ((cnt_q == 2'h1 && !pop) || cnt_q == `UFSD_BUF_DEPTH)) begin
					ent1_q <= i_in_data;
				end
				if (push && !pop) begin
					cnt_q <= cnt_q + 2'h1;
				end else if (pop && !push) begin
					cnt_q <= cnt_q - 2'h1;
				end
			end
		end
	end
endmodule // ufsd_buf

`default_nettype wire

// *** hw/ufsd_decoder.v ***
// slave-receiver address decoder for the unidirectional two-wire bus
// assumes: bus lines are asynchronous pins, system clock much faster than the bus clock
`timescale 1ns/10ps
`default_nettype none
`include "ufsd_defs.vh"

module ufsd_decoder (
	// clock and reset
	input wire i_clk_sys,
	input wire i_rst,
	input wire i_ce,
	// bus pins, input only
	input wire i_uscl,
	input wire i_usda,
	// own address configuration
	input wire [6:0] i_own_addr7,
	input wire [9:0] i_own_addr10,
	input wire i_ten_bit_en,
	input wire i_gc_en,
	input wire i_swrst_en,
	input wire [`UFSD_PROG_W-1:0] i_prog_pins,
	// received data stream
	output wire o_rx_valid,
	output wire [`UFSD_BYTE_W-1:0] o_rx_data,
	input wire i_rx_ready,
	// status
	output reg o_addressed,
	output reg o_busy,
	output reg o_overrun,
	output reg o_soft_reset,
	output reg o_prog_load,
	output reg [`UFSD_PROG_W-1:0] o_prog_addr
);
	// ************
	// states and first byte classes
	// ************
	localparam ST_IDLE = 3'h0;
	localparam ST_ADDR1 = 3'h1;
	localparam ST_ADDR2 = 3'h2;
	localparam ST_DATA = 3'h3;
	localparam ST_GC2 = 3'h4;
	localparam ST_DISC = 3'h5;
	localparam ST_LEGACY = 3'h6;

	localparam CL_GC = 3'h0;
	localparam CL_STARTB = 3'h1;
	localparam CL_LEGACY = 3'h2;
	localparam CL_RSVD = 3'h3;
	localparam CL_TEN = 3'h4;
	localparam CL_SEVEN = 3'h5;

	// ************
	// address byte fields
	// ************
	// seven address bits above the direction bit
	function [6:0] addr_field;
		input [`UFSD_BYTE_W-1:0] b;
		begin
			addr_field = b[`UFSD_ADDR_HI:`UFSD_ADDR_LO];
		end
	endfunction

	function is_write;
		input [`UFSD_BYTE_W-1:0] b;
		begin
			is_write = (b[`UFSD_DIR_POS] == `UFSD_DIR_WRITE);
		end
	endfunction

	// top five bits split ten-bit prefix from high reserved group
	function [4:0] top_field;
		input [`UFSD_BYTE_W-1:0] b;
		begin
			top_field = b[`UFSD_ADDR_HI:`UFSD_TOP_LO];
		end
	endfunction

	// upper two bits of a ten-bit address inside the prefix byte
	function [1:0] ten_upper;
		input [`UFSD_BYTE_W-1:0] b;
		begin
			ten_upper = b[`UFSD_UP_HI:`UFSD_UP_LO];
		end
	endfunction

	// ************
	// first byte classification
	// ************
	// reserved groups
	function [2:0] addr_class;
		input [`UFSD_BYTE_W-1:0] b;
		begin
			if (addr_field(b) == `UFSD_ADDR_ZERO) begin
				addr_class = is_write(b) ? CL_GC : CL_STARTB;
			end else if (addr_field(b) == `UFSD_ADDR_LEGACY) begin
				addr_class = CL_LEGACY;
			end else if (b[`UFSD_ADDR_HI:`UFSD_GRP_LO] == `UFSD_LOW_GROUP) begin
				addr_class = CL_RSVD;
			end else if (top_field(b) == `UFSD_HIGH_RSVD) begin
				addr_class = CL_RSVD;
			end else if (top_field(b) == `UFSD_TEN_PREFIX) begin
				addr_class = CL_TEN;
			end else begin
				addr_class = CL_SEVEN;
			end
		end
	endfunction

	// ************
	// pin synchronisers
	// ************
	reg [1:0] sync1_q;
	reg [1:0] sync2_q;
	reg [1:0] sync3_q;
	reg scl_lvl_q;
	reg sda_lvl_q;
	wire scl_ok;
	wire sda_ok;
	wire scl_new;
	wire sda_new;
	wire scl_rise;
	wire start_det;
	wire stop_det;

	always @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			sync1_q <= 2'h3;
			sync2_q <= 2'h3;
			sync3_q <= 2'h3;
			scl_lvl_q <= 1'h1;
			sda_lvl_q <= 1'h1;
		end else if (i_ce) begin
			sync1_q <= {i_uscl, i_usda};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			if (scl_ok) begin
				scl_lvl_q <= scl_new;
			end
			if (sda_ok) begin
				sda_lvl_q <= sda_new;
			end
		end
	end

	// a change counts once second and third stage agree
	// first stage may settle late, so nothing but the second reads it
	assign scl_ok = (sync2_q[1] == sync3_q[1]);
	assign sda_ok = (sync2_q[0] == sync3_q[0]);
	assign scl_new = sync3_q[1];
	assign sda_new = sync3_q[0];
	assign scl_rise = scl_ok & scl_new & ~scl_lvl_q;
	assign start_det = sda_ok & ~sda_new & sda_lvl_q & scl_lvl_q & scl_new;
	assign stop_det = sda_ok & sda_new & ~sda_lvl_q & scl_lvl_q & scl_new;

	// ************
	// bit shifter
	// ************
	reg [`UFSD_BYTE_W-2:0] shift_q;
	reg [`UFSD_BIT_CNT_W-1:0] bit_q;
	wire byte_done;
	wire [`UFSD_BYTE_W-1:0] rx_byte;

	assign rx_byte = {shift_q, sda_lvl_q};
	assign byte_done = scl_rise & (bit_q == `UFSD_LAST_DATA_BIT);

	always @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			shift_q <= 7'h00;
			bit_q <= `UFSD_BIT_ZERO;
		end else if (i_ce) begin
			if (start_det) begin
				bit_q <= `UFSD_BIT_ZERO;
			end else if (scl_rise) begin
				shift_q <= rx_byte[`UFSD_BYTE_W-2:0];
				// ninth bit sampled but never used
				if (bit_q == `UFSD_ACK_BIT) begin
					bit_q <= `UFSD_BIT_ZERO;
				end else begin
					bit_q <= bit_q + 4'h1;
				end
			end
		end
	end

	// ************
	// effective addresses
	// ************
	wire [6:0] eff7;
	wire [9:0] eff10;
	reg [`UFSD_PROG_W-1:0] prog_q;

	assign eff7 = {i_own_addr7[6:`UFSD_PROG_W], prog_q};
	assign eff10 = {i_own_addr10[9:`UFSD_PROG_W], prog_q};

	// ************
	// decoder state machine
	// ************
	reg [2:0] st_q;
	reg [2:0] st_d;
	reg sel10_q;
	reg sel10_d;
	reg push;
	reg flush;
	reg do_reset;
	reg do_prog;
	wire buf_ready;

	always @* begin
		st_d = st_q;
		sel10_d = sel10_q;
		push = 1'b0;
		flush = 1'b0;
		do_reset = 1'b0;
		do_prog = 1'b0;
		if (st_q == ST_LEGACY) begin
			if (stop_det) begin
				st_d = ST_IDLE;
			end
		end else if (stop_det) begin
			st_d = ST_IDLE;
			sel10_d = 1'b0;
		end else if (start_det) begin
			st_d = ST_ADDR1;
		end else if (byte_done) begin
			case (st_q)
				ST_ADDR1: begin
					sel10_d = 1'b0;
					st_d = ST_DISC;
					case (addr_class(rx_byte))
						CL_GC: begin
							if (i_gc_en) begin
								st_d = ST_GC2;
							end
						end
						CL_STARTB: begin
							st_d = ST_DISC;
						end
						CL_LEGACY: begin
							st_d = ST_LEGACY;
						end
						CL_TEN: begin
							if (i_ten_bit_en &&
								ten_upper(rx_byte) == eff10[`UFSD_TEN_UP_HI:`UFSD_TEN_UP_LO] &&
								is_write(rx_byte)) begin
								st_d = ST_ADDR2;
								sel10_d = sel10_q;
							end
						end
						CL_SEVEN: begin
							if (addr_field(rx_byte) == eff7 && is_write(rx_byte)) begin
								st_d = ST_DATA;
							end
						end
						default: begin
							st_d = ST_DISC;
						end
					endcase
				end
				ST_ADDR2: begin
					if (rx_byte == eff10[`UFSD_BYTE_W-1:0]) begin
						st_d = ST_DATA;
						sel10_d = 1'b1;
					end else begin
						st_d = ST_DISC;
						sel10_d = 1'b0;
					end
				end
				ST_DATA: begin
					push = 1'b1;
				end
				ST_GC2: begin
					st_d = ST_DISC;
					if (rx_byte == `UFSD_GC_RESET_PROG && i_swrst_en) begin
						do_reset = 1'b1;
						do_prog = 1'b1;
						flush = 1'b1;
						sel10_d = 1'b0;
					end else if (rx_byte == `UFSD_GC_PROG) begin
						do_prog = 1'b1;
					end
				end
				ST_DISC: begin
					st_d = ST_DISC;
				end
				default: begin
					st_d = ST_IDLE;
				end
			endcase
		end
	end

	always @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			st_q <= ST_IDLE;
			sel10_q <= 1'b0;
			prog_q <= `UFSD_PROG_RST;
			o_addressed <= 1'b0;
			o_busy <= 1'b0;
			o_overrun <= 1'b0;
			o_soft_reset <= 1'b0;
			o_prog_load <= 1'b0;
			o_prog_addr <= `UFSD_PROG_RST;
		end else if (i_ce) begin
			st_q <= st_d;
			sel10_q <= sel10_d;
			o_addressed <= sel10_d | (st_d == ST_DATA);
			o_busy <= (st_d != ST_IDLE);
			o_overrun <= push & ~buf_ready;
			o_soft_reset <= do_reset;
			o_prog_load <= do_prog;
			if (do_prog) begin
				prog_q <= i_prog_pins;
				o_prog_addr <= i_prog_pins;
			end
		end
	end

	// ************
	// receive buffer
	// ************
	ufsd_buf u_buf (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_flush(flush),
		.i_in_valid(push),
		.i_in_data(rx_byte),
		.o_in_ready(buf_ready),
		.o_out_valid(o_rx_valid),
		.o_out_data(o_rx_data),
		.i_out_ready(i_rx_ready)
	);
endmodule // ufsd_decoder

`default_nettype wire

// *** hw/ufsd_defs.vh ***
// constants of the ultra fast-mode slave address decoder
// assumes: included by bare name from hw/ufsd_decoder.v and hw/ufsd_buf.v
// Behaviour
// - ten-bit addressing carries writes only; direction never changes mid message.
// - after start, match 11110 plus own two upper bits, direction zero.
// - after prefix match, all eight bits of next byte must equal own low byte.
// - selected ten-bit slave stays addressed until stop or start with other address.
// - groups 0000xxx and 1111xxx are special: broadcast, start byte, ten-bit, reserved.
// - a broadcast-capable slave receives after all-zero address with write direction.
// - broadcast bytes the slave cannot process are discarded.
// - second broadcast byte gives meaning; lsb one ignores whole sequence.
// - second byte 06h resets the slave, then loads the programmable address part.
// - second byte 04h loads the programmable address part without reset.
// - master never sends 00h second byte; slaves ignore all undefined codes.
// - answering the software reset sequence is optional.
// - the repeated start after the start byte resets the receiver.
// - the start byte is never acknowledged; its ninth clock only keeps format.
// - no device identification read-out exists in this mode.
// - legacy three-wire address is never answered; message ignored until stop.
// - every start or repeated start resets bus logic to expect an address. Decoder ignores starts in ST_LEGACY until stop.
// - start is data falling while clock high; stop is data rising while clock high.
// - every byte is eight bits, most significant bit first.
`ifndef UFSD_DEFS_VH
`define UFSD_DEFS_VH

// ************
// bytes and bits
// ************
`define UFSD_BYTE_W 8
`define UFSD_BIT_CNT_W 4
`define UFSD_LAST_DATA_BIT 4'h7
`define UFSD_ACK_BIT 4'h8
`define UFSD_BIT_ZERO 4'h0

// ************
// first byte classes
// ************
`define UFSD_ADDR_ZERO 7'h00
`define UFSD_ADDR_LEGACY 7'h01
`define UFSD_LOW_GROUP 4'h0
`define UFSD_TEN_PREFIX 5'h1e
`define UFSD_HIGH_RSVD 5'h1f
`define UFSD_DIR_WRITE 1'h0

// ************
// field positions in an address byte and in the ten-bit address
// ************
`define UFSD_DIR_POS 0
`define UFSD_ADDR_HI 7
`define UFSD_ADDR_LO 1
`define UFSD_GRP_LO 4
`define UFSD_TOP_LO 3
`define UFSD_UP_HI 2
`define UFSD_UP_LO 1
`define UFSD_TEN_UP_HI 9
`define UFSD_TEN_UP_LO 8

// ************
// broadcast second byte codes
// ************
`define UFSD_GC_RESET_PROG 8'h06
`define UFSD_GC_PROG 8'h04

// ************
// address and buffer widths, buffer depth and reset values
// ************
`define UFSD_PROG_W 2
`define UFSD_PROG_RST 2'h0
`define UFSD_BUF_CNT_W 2
`define UFSD_BUF_DEPTH 2'h2
`define UFSD_BUF_EMPTY 2'h0

`endif

// *** verification/ufsd_bus_master.sv ***
// single bus master driving clock and data push-pull
// assumes: 8 system cycles per bus bit, clock still between frames
`timescale 1ns/10ps
`default_nettype none
// ************
// master model
// ************
module ufsd_bus_master (
	input wire logic i_clk_sys,
	output logic o_uscl,
	output logic o_usda
);
	initial begin
		o_uscl = 1'b1;
		o_usda = 1'b1;
	end
	task automatic q(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask
	task automatic sta();
		o_usda = 1'b1;
		q(2);
		o_uscl = 1'b1;
		q(4);
		o_usda = 1'b0;
		q(4);
		o_uscl = 1'b0;
		q(2);
	endtask
	task automatic sto();
		o_usda = 1'b0;
		q(2);
		o_uscl = 1'b1;
		q(4);
		o_usda = 1'b1;
		q(4);
	endtask
	task automatic bit1(input logic v);
		o_usda = v;
		q(2);
		o_uscl = 1'b1;
		q(4);
		o_uscl = 1'b0;
		q(2);
	endtask
	task automatic put(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) bit1(b[i]);
		bit1(1'b1);
	endtask
endmodule // ufsd_bus_master
`default_nettype wire

// *** verification/ufsd_decoder_props.sv ***
// port assertions for the two-wire slave decoder
// assumes: bound to ufsd_decoder, one clock domain
`timescale 1ns/10ps
`default_nettype none
// ************
// checker
// ************
module ufsd_decoder_props (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_gc_en,
	input wire logic i_swrst_en,
	input wire logic i_rx_ready,
	input wire logic o_rx_valid,
	input wire logic [7:0] o_rx_data,
	input wire logic o_addressed,
	input wire logic o_busy,
	input wire logic o_overrun,
	input wire logic o_soft_reset,
	input wire logic o_prog_load,
	input wire logic [1:0] o_prog_addr
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);
	a_head_holds: assert property ((o_rx_valid && !i_rx_ready) ##1 !o_soft_reset |-> o_rx_valid && $stable(o_rx_data))
		else $error("held head byte changed");
	a_stop_drops_sel: assert property ($fell(o_busy) |-> !o_addressed)
		else $error("still selected after stop");
	a_sel_in_msg: assert property (o_addressed |-> o_busy)
		else $error("selected while bus idle");
	a_rst_pulse_once: assert property (o_soft_reset |=> !o_soft_reset)
		else $error("soft reset pulse too long");
	a_rst_loads: assert property (o_soft_reset |-> o_prog_load && i_swrst_en)
		else $error("soft reset without load");
	a_load_needs_gc: assert property (o_prog_load |-> i_gc_en)
		else $error("load with broadcast off");
	a_addr_on_load: assert property ($changed(o_prog_addr) |-> o_prog_load)
		else $error("address part changed without load");
	a_ovr_full: assert property (o_overrun |-> o_rx_valid)
		else $error("overrun with empty buffer");
	a_push_in_msg: assert property ($rose(o_rx_valid) |-> $past(o_busy))
		else $error("byte pushed outside a message");
	c_load: cover property (o_prog_load);
	c_reset: cover property (o_soft_reset);
	c_overrun: cover property (o_overrun);
endmodule // ufsd_decoder_props

bind ufsd_decoder ufsd_decoder_props i_props (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_gc_en(i_gc_en),
	.i_swrst_en(i_swrst_en), .i_rx_ready(i_rx_ready), .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data),
	.o_addressed(o_addressed), .o_busy(o_busy), .o_overrun(o_overrun), .o_soft_reset(o_soft_reset),
	.o_prog_load(o_prog_load), .o_prog_addr(o_prog_addr));
`default_nettype wire

// *** verification/ufsd_decoder_test.sv ***
// self-checking bench for the two-wire slave decoder
// assumes: design under hw/, master model drives the bus pins
`timescale 1ns/10ps
`default_nettype none
// ************
// bench
// ************
module ufsd_decoder_test;
	logic i_clk_sys, i_rst, gc_en, rx_ready, rx_valid, addressed, busy, ovr, srst, load;
	logic ce, ten_en, swrst_en;
	logic [6:0] own7;
	logic [9:0] own10;
	logic saw_rst, saw_load, saw_ovr;
	logic [1:0] prog, prog_addr;
	logic [7:0] rx_data;
	logic [7:0] got[$];
	wire uscl, usda;
	int errors = 0, compares = 0, cycles = 0;
	ufsd_bus_master m (.i_clk_sys(i_clk_sys), .o_uscl(uscl), .o_usda(usda));
	ufsd_decoder i_ufsd_decoder (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(ce), .i_uscl(uscl),
		.i_usda(usda), .i_own_addr7(own7), .i_own_addr10(own10), .i_ten_bit_en(ten_en), .i_gc_en(gc_en),
		.i_swrst_en(swrst_en), .i_prog_pins(prog), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
		.i_rx_ready(rx_ready), .o_addressed(addressed), .o_busy(busy), .o_overrun(ovr),
		.o_soft_reset(srst), .o_prog_load(load), .o_prog_addr(prog_addr));
	initial begin
		i_clk_sys = 1'b0;
		forever #20 i_clk_sys = ~i_clk_sys;
	end
	always @(posedge i_clk_sys) begin
		cycles++;
		if (rx_valid === 1'b1 && rx_ready === 1'b1) got.push_back(rx_data);
		if (srst === 1'b1) saw_rst = 1'b1;
		if (load === 1'b1) saw_load = 1'b1;
		if (ovr === 1'b1) saw_ovr = 1'b1;
		if (cycles == 12000) begin
			errors++;
			wrap_up();
		end
	end
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] a);
		compares++;
		if (a !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, a);
		end
	endtask
	task automatic rx_is(input logic [7:0] n, input logic [7:0] b0, input logic [7:0] b1);
		chk("rx count", n, 8'(got.size()));
		if (n > 0 && got.size() > 0) chk("rx byte0", b0, got[0]);
		if (n > 1 && got.size() > 1) chk("rx byte1", b1, got[1]);
		got.delete();
	endtask
	task automatic t_seven();
		m.sta();
		m.put(8'h50);
		m.put(8'ha5);
		m.put(8'h3c);
		chk("selected", 8'h01, {7'h00, addressed});
		chk("busy", 8'h01, {7'h00, busy});
		m.sto();
		chk("busy", 8'h00, {7'h00, busy});
		chk("selected", 8'h00, {7'h00, addressed});
		rx_is(8'h02, 8'ha5, 8'h3c);
	endtask
	task automatic t_ignored();
		logic [7:0] firsts[7] = '{8'h51, 8'h01, 8'h08, 8'hfc, 8'h52, 8'hf5, 8'h00};
		foreach (firsts[i]) begin
			m.sta();
			m.put(firsts[i]);
			m.put(8'h50);
			m.sto();
		end
		rx_is(8'h00, 8'h00, 8'h00);
	endtask
	task automatic t_legacy();
		m.sta();
		m.put(8'h02);
		m.put(8'h77);
		m.sta();
		m.put(8'h50);
		m.put(8'h66);
		rx_is(8'h00, 8'h00, 8'h00);
		m.sto();
		m.sta();
		m.put(8'h50);
		m.put(8'h99);
		m.sto();
		rx_is(8'h01, 8'h99, 8'h00);
	endtask
	task automatic t_ten();
		m.sta();
		m.put(8'h01);
		m.sta();
		m.put(8'hf4);
		m.put(8'hb4);
		m.put(8'h5a);
		m.sta();
		m.put(8'hf4);
		chk("ten held", 8'h01, {7'h00, addressed});
		m.put(8'hb4);
		m.put(8'hc3);
		m.sta();
		m.put(8'hf4);
		m.put(8'hb0);
		m.put(8'h11);
		chk("ten sel", 8'h00, {7'h00, addressed});
		m.sto();
		rx_is(8'h02, 8'h5a, 8'hc3);
	endtask
	task automatic t_gc();
		gc_en = 1'b1;
		prog = 2'b11;
		saw_load = 1'b0;
		saw_rst = 1'b0;
		m.sta();
		m.put(8'h00);
		m.put(8'h05);
		m.sta();
		m.put(8'h00);
		m.put(8'h02);
		m.sto();
		chk("odd code load", 8'h00, {7'h00, saw_load});
		m.sta();
		m.put(8'h00);
		m.put(8'h04);
		m.sto();
		chk("prog part", 8'h03, {6'h00, prog_addr});
		chk("no reset", 8'h00, {7'h00, saw_rst});
		prog = 2'b01;
		m.sta();
		m.put(8'h00);
		m.put(8'h06);
		m.sto();
		chk("soft reset", 8'h01, {7'h00, saw_rst});
		chk("prog part", 8'h01, {6'h00, prog_addr});
		got.delete();
		m.sta();
		m.put(8'h52);
		m.put(8'h4e);
		m.sto();
		rx_is(8'h01, 8'h4e, 8'h00);
	endtask
	task automatic t_overrun();
		rx_ready = 1'b0;
		saw_ovr = 1'b0;
		m.sta();
		m.put(8'h52);
		m.put(8'h11);
		m.put(8'h22);
		m.put(8'h33);
		m.sto();
		chk("overrun", 8'h01, {7'h00, saw_ovr});
		rx_ready = 1'b1;
		m.q(4);
		rx_is(8'h02, 8'h11, 8'h22);
	endtask
	task automatic t_enables();
		swrst_en = 1'b0;
		prog = 2'b10;
		saw_rst = 1'b0;
		saw_load = 1'b0;
		m.sta();
		m.put(8'h00);
		m.put(8'h06);
		m.sto();
		chk("reset off", 8'h00, {7'h00, saw_rst});
		chk("load off", 8'h00, {7'h00, saw_load});
		chk("prog kept", 8'h01, {6'h00, prog_addr});
		swrst_en = 1'b1;
		ten_en = 1'b0;
		m.sta();
		m.put(8'hf4);
		m.put(8'hb5);
		m.put(8'h77);
		chk("ten off", 8'h00, {7'h00, addressed});
		m.sto();
		rx_is(8'h00, 8'h00, 8'h00);
		ten_en = 1'b1;
		m.sta();
		m.put(8'hf4);
		m.put(8'hb5);
		m.put(8'h78);
		m.sto();
		rx_is(8'h01, 8'h78, 8'h00);
		ce = 1'b0;
		m.sta();
		m.put(8'h52);
		m.put(8'h44);
		m.sto();
		ce = 1'b1;
		m.q(4);
		chk("frozen busy", 8'h00, {7'h00, busy});
		rx_is(8'h00, 8'h00, 8'h00);
	endtask
	task automatic wrap_up();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		i_rst = 1'b1;
		gc_en = 1'b0;
		rx_ready = 1'b1;
		prog = 2'b00;
		ce = 1'b1;
		ten_en = 1'b1;
		swrst_en = 1'b1;
		own7 = 7'h28;
		own10 = 10'h2b4;
		repeat (10) @(posedge i_clk_sys);
		#1;
		i_rst = 1'b0;
		m.q(4);
		t_seven();
		t_ignored();
		t_legacy();
		t_ten();
		t_gc();
		t_overrun();
		t_enables();
		wrap_up();
	end
endmodule // ufsd_decoder_test
`default_nettype wire
